// ---- src/sfr_pkg.sv ----
// constants shared by the security fault response block
package sfr_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUS_TMO_NS = 640;
    localparam int BUS_TMO_CYC = (BUS_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_HOLD_NS = 160;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] SFR_CTRL = 8'h00;
    localparam logic [7:0] SFR_CRIT = 8'h04;
    localparam logic [7:0] SFR_STAT = 8'h08;
    localparam logic [7:0] SFR_MASK = 8'h0c;
    localparam logic [7:0] SFR_CAUSE = 8'h10;
    localparam logic [7:0] SFR_WDT_PER = 8'h14;
    localparam logic [7:0] SFR_WDT_KICK = 8'h18;
    localparam logic [7:0] SFR_CHKPT = 8'h1c;
    localparam logic [7:0] SFR_TEST = 8'h20;
    localparam logic [7:0] SFR_FIX_CNT = 8'h24;

    // control bit positions
    localparam int CTRL_TEST_GO = 0;
    localparam int CTRL_BUS_EN = 1;
    localparam int CTRL_WDT_EN = 2;

    // event sources, one bit each in status, cause, mask, crit, test
    localparam int NSRC = 12;
    localparam int EV_MEM_FATAL = 0;
    localparam int EV_MEM_FIX = 1;
    localparam int EV_ROM = 2;
    localparam int EV_TEAR = 3;
    localparam int EV_CPU_CMP = 4;
    localparam int EV_SENSOR = 5;
    localparam int EV_WDT = 6;
    localparam int EV_CHKPT = 7;
    localparam int EV_SCP = 8;
    localparam int EV_BUS = 9;
    localparam int EV_MMU = 10;
    localparam int EV_OPCODE = 11;

    // sources that always end in the secure state
    localparam logic [NSRC-1:0] FORCED_CRIT = 12'h43d;
    // values after reset
    localparam logic [NSRC-1:0] CRIT_RST = 12'h1c0;
    localparam logic [NSRC-1:0] MASK_RST = 12'h000;
    localparam logic [31:0] WDT_PER_RST = 32'h0001_0000;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // memory regions seen by the check code
    localparam logic [1:0] REG_RAM = 2'h0;
    localparam logic [1:0] REG_ROM = 2'h1;
    localparam logic [1:0] REG_NVM = 2'h2;

    typedef enum logic [2:0] {
        SFR_ST_INIT = 3'b001,
        SFR_ST_RUN = 3'b010,
        SFR_ST_TEST = 3'b100
    } sfr_state_e;
endpackage

// ---- src/sfr_top.sv ----
// security fault response: alarm collection, reset and secure state
// Functional notes
// - check all memory paths, flag corruption
// - correct single NVM bit errors, no fatal alarm
// - check ROM contents against stored check value
// - tear during NVM program: abort, power-on restart
// - compare both CPU results at completion
// - CPU mismatch recorded, then secure state, reset
// - self-test only after boot firmware finishes
// - attack sensor halts CPU, security reset
// - watchdog timer and checkpoint register provided
// - crypto backward result compared against input
// - bus handshake monitored, alarm when failed
// - access violation resets, then trap entered
// - illegal opcode gives security reset only when its crit bit is set
// - critical errors alarm and end secure
// - MMU loaded with defaults at start-up
`timescale 1ns/1ps
`default_nettype none
module sfr_top #(
    parameter int MMU_N = 4,
    parameter logic [31:0] ROM_REF = 32'h0000_0000
) (
    // clock, resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory check code
    input wire logic mem_chk_valid,
    input wire logic [1:0] mem_chk_region,
    input wire logic mem_err_single,
    input wire logic mem_err_multi,
    input wire logic [31:0] mem_raw_data,
    input wire logic [31:0] mem_flip_mask,
    output logic [31:0] mem_fix_data,
    output logic mem_fix_valid,
    // rom scan
    input wire logic rom_word_valid,
    input wire logic rom_word_last,
    input wire logic [31:0] rom_word,
    // nvm programming
    input wire logic nvm_prog_busy,
    input wire logic nvm_tear,
    output logic nvm_abort,
    output logic por_req,
    // dual cpu
    input wire logic cpu_done,
    input wire logic [31:0] cpu_a_res,
    input wire logic [31:0] cpu_b_res,
    input wire logic cpu_illegal_op,
    output logic cpu_halt,
    output logic cpu_run,
    // crypto coprocessor
    input wire logic scp_chk_valid,
    input wire logic [31:0] scp_in,
    input wire logic [31:0] scp_back,
    // bus handshake
    input wire logic bus_req,
    input wire logic bus_ack,
    input wire logic bus_err,
    // mmu
    input wire logic mmu_viol,
    output logic mmu_cfg_we,
    output logic [7:0] mmu_cfg_idx,
    output logic [31:0] mmu_cfg_data,
    output logic trap_req,
    // attack sensor pins, active low
    input wire logic [3:0] sensor_n,
    // boot firmware
    input wire logic boot_done,
    // chip reset and interrupt
    output logic chip_rst_req,
    output logic secure_state,
    output logic irq
);
    import sfr_pkg::*;

    // predefined mmu entries
    function automatic logic [31:0] mmu_default(input logic [7:0] idx);
        mmu_default = {idx, 8'h00, 16'h0f00};
    endfunction

    logic [2:0] ctrl_q;
    logic [NSRC-1:0] crit_q, stat_q, mask_q, cause_q, pass_q;
    logic [31:0] wdt_per_q, wdt_cnt_q, chk_last_q, rom_sum_q, fix_cnt_q;
    logic [31:0] rom_sum_d, rdata_d;
    logic [15:0] bus_cnt_q;
    logic [7:0] rst_cnt_q, init_idx_q;
    logic [3:0] sens_m_q, sens_s_q, tidx_q;
    logic test_done_q;
    logic [NSRC-1:0] ev_live, inj, ev_test;
    logic wr, rd_ok, kick, chk_wr, test_go, bus_tmo, any_crit;
    sfr_state_e state_q;

    // apb decode
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign kick = wr & (paddr == SFR_WDT_KICK);
    assign chk_wr = wr & (paddr == SFR_CHKPT);

    // sensor pins pass two flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sens_m_q <= 4'hf;
            sens_s_q <= 4'hf;
        end else begin
            sens_m_q <= sensor_n;
            sens_s_q <= sens_m_q;
        end
    end

    // rom check value accumulation
    assign rom_sum_d = {rom_sum_q[30:0], rom_sum_q[31]} ^ rom_word;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_sum_q <= 32'h0;
        end else if (rom_word_valid) begin
            rom_sum_q <= rom_word_last ? 32'h0 : rom_sum_d;
        end
    end

    // bus handshake watch
    assign bus_tmo = bus_cnt_q == 16'(BUS_TMO_CYC);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_cnt_q <= 16'h0;
        end else if (!bus_req || bus_ack || bus_tmo) begin
            bus_cnt_q <= 16'h0;
        end else begin
            bus_cnt_q <= bus_cnt_q + 16'h1;
        end
    end

    // detectors
    always_comb begin
        ev_live = '0;
        ev_live[EV_MEM_FATAL] = mem_chk_valid & (mem_err_multi |
            (mem_err_single & (mem_chk_region != REG_NVM)));
        ev_live[EV_MEM_FIX] = mem_chk_valid & mem_err_single &
            ~mem_err_multi & (mem_chk_region == REG_NVM);
        ev_live[EV_ROM] = rom_word_valid & rom_word_last &
            (rom_sum_d != ROM_REF);
        ev_live[EV_TEAR] = nvm_prog_busy & nvm_tear;
        ev_live[EV_CPU_CMP] = cpu_done & (cpu_a_res != cpu_b_res);
        ev_live[EV_SENSOR] = ~&sens_s_q;
        ev_live[EV_WDT] = ctrl_q[CTRL_WDT_EN] & ~kick &
            (wdt_cnt_q == wdt_per_q);
        ev_live[EV_CHKPT] = chk_wr & (pwdata != chk_last_q + 32'h1);
        ev_live[EV_SCP] = scp_chk_valid & (scp_back != scp_in);
        ev_live[EV_BUS] = ctrl_q[CTRL_BUS_EN] &
            (bus_tmo | (bus_ack & bus_err));
        ev_live[EV_MMU] = mmu_viol;
        ev_live[EV_OPCODE] = cpu_illegal_op;
    end

    // self-test injection, one source at a time
    assign inj = (state_q == SFR_ST_TEST) ?
        NSRC'(12'h1 << tidx_q) : '0;
    assign ev_test = ev_live | inj;
    assign any_crit = |(ev_live & (crit_q | FORCED_CRIT));
    assign test_go = wr & (paddr == SFR_CTRL) & pwdata[CTRL_TEST_GO] &
        boot_done;

    // start-up, run and self-test sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SFR_ST_INIT;
            init_idx_q <= 8'h0;
            tidx_q <= 4'h0;
            pass_q <= '0;
            test_done_q <= 1'b0;
        end else begin
            unique case (state_q)
                SFR_ST_INIT: begin
                    init_idx_q <= init_idx_q + 8'h1;
                    if (init_idx_q == 8'(MMU_N - 1)) begin
                        state_q <= SFR_ST_RUN;
                    end
                end
                SFR_ST_RUN: begin
                    if (test_go) begin
                        state_q <= SFR_ST_TEST;
                        tidx_q <= 4'h0;
                        pass_q <= '0;
                        test_done_q <= 1'b0;
                    end
                end
                SFR_ST_TEST: begin
                    pass_q <= pass_q | (ev_test & inj);
                    tidx_q <= tidx_q + 4'h1;
                    if (tidx_q == 4'(NSRC - 1)) begin
                        state_q <= SFR_ST_RUN;
                        test_done_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // mmu default load, cpu held until done
    assign mmu_cfg_we = state_q == SFR_ST_INIT;
    assign mmu_cfg_idx = init_idx_q;
    assign mmu_cfg_data = mmu_default(init_idx_q);
    assign cpu_run = (state_q != SFR_ST_INIT) & ~cpu_halt & ~secure_state;

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            crit_q <= CRIT_RST;
            mask_q <= MASK_RST;
            wdt_per_q <= WDT_PER_RST;
        end else if (wr) begin
            if (paddr == SFR_CTRL) begin
                ctrl_q <= {pwdata[2:1], 1'b0};
            end
            if (paddr == SFR_CRIT) begin
                crit_q <= pwdata[NSRC-1:0];
            end
            if (paddr == SFR_MASK) begin
                mask_q <= pwdata[NSRC-1:0];
            end
            if (paddr == SFR_WDT_PER) begin
                wdt_per_q <= pwdata;
            end
        end
    end

    // watchdog and checkpoint
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_q <= 32'h0;
            chk_last_q <= 32'h0;
        end else begin
            if (kick || !ctrl_q[CTRL_WDT_EN] || wdt_cnt_q == wdt_per_q) begin
                wdt_cnt_q <= 32'h0;
            end else begin
                wdt_cnt_q <= wdt_cnt_q + 32'h1;
            end
            if (chk_wr) begin
                chk_last_q <= pwdata;
            end
        end
    end

    // sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
        end else if (wr && paddr == SFR_STAT) begin
            stat_q <= (stat_q & ~pwdata[NSRC-1:0]) | ev_live;
        end else begin
            stat_q <= stat_q | ev_live;
        end
    end
    assign irq = |(stat_q & mask_q);

    // cause kept across the chip reset, cleared only by power-on or by writing ones
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            cause_q <= '0;
        end else if (wr && paddr == SFR_CAUSE) begin
            cause_q <= (cause_q & ~pwdata[NSRC-1:0]) | ev_live;
        end else begin
            cause_q <= cause_q | ev_live;
        end
    end

    // corrected nvm data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_fix_data <= 32'h0;
            mem_fix_valid <= 1'b0;
            fix_cnt_q <= 32'h0;
        end else begin
            mem_fix_valid <= ev_live[EV_MEM_FIX];
            if (ev_live[EV_MEM_FIX]) begin
                mem_fix_data <= mem_raw_data ^ mem_flip_mask;
                fix_cnt_q <= fix_cnt_q + 32'h1;
            end
        end
    end

    // reset request, secure state, halt, trap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_q <= 8'h0;
            chip_rst_req <= 1'b0;
            secure_state <= 1'b0;
            cpu_halt <= 1'b0;
            trap_req <= 1'b0;
            por_req <= 1'b0;
            nvm_abort <= 1'b0;
        end else begin
            if (any_crit) begin
                rst_cnt_q <= 8'(RST_HOLD_CYC);
                secure_state <= 1'b1;
            end else if (rst_cnt_q != 8'h0) begin
                rst_cnt_q <= rst_cnt_q - 8'h1;
            end
            chip_rst_req <= any_crit | (rst_cnt_q > 8'h1);
            if (ev_live[EV_SENSOR]) begin
                cpu_halt <= 1'b1;
            end
            if (ev_live[EV_MMU]) begin
                trap_req <= 1'b1;
            end
            if (ev_live[EV_TEAR]) begin
                por_req <= 1'b1;
            end
            nvm_abort <= ev_live[EV_TEAR];
        end
    end

    // apb read data
    always_comb begin
        rdata_d = 32'h0;
        rd_ok = 1'b1;
        unique case (paddr)
            SFR_CTRL: rdata_d = {29'h0, ctrl_q};
            SFR_CRIT: rdata_d = {20'h0, crit_q};
            SFR_STAT: rdata_d = {20'h0, stat_q};
            SFR_MASK: rdata_d = {20'h0, mask_q};
            SFR_CAUSE: rdata_d = {20'h0, cause_q};
            SFR_WDT_PER: rdata_d = wdt_per_q;
            SFR_WDT_KICK: rdata_d = wdt_cnt_q;
            SFR_CHKPT: rdata_d = chk_last_q;
            SFR_TEST: rdata_d = {test_done_q, 3'h0,
                state_q == SFR_ST_TEST, 15'h0, pass_q};
            SFR_FIX_CNT: rdata_d = fix_cnt_q;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end
    assign pslverr = psel & penable & ~rd_ok;
endmodule
`default_nettype wire

// ---- test/sfr_far_side.sv ----
// far-side model: dual cpu result pair and a bus master
`timescale 1ns/1ps
`default_nettype none
module sfr_far_side (
    // clock, reset
    input wire logic pclk,
    input wire logic presetn,
    // scenario controls
    input wire logic job,
    input wire logic bad,
    input wire logic hold,
    // cpu results and bus handshake
    output logic cpu_done,
    output logic [31:0] cpu_a_res,
    output logic [31:0] cpu_b_res,
    output logic bus_req,
    output logic bus_ack,
    output logic bus_err
);
    logic [2:0] job_q;
    logic [1:0] ph_q;
    logic [31:0] pat_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            job_q <= 3'h0;
            ph_q <= 2'h0;
            pat_q <= 32'h0;
        end else begin
            job_q <= {job_q[1:0], job};
            ph_q <= ph_q + 2'h1;
            pat_q <= pat_q + 32'h3579_bdf1;
        end
    end
    // both halves share one operand; idle results keep moving
    assign cpu_done = job_q[2];
    assign cpu_a_res = cpu_done ? 32'h5a5a_0f0f : pat_q;
    assign cpu_b_res = cpu_done ? 32'h5a5a_0f0f ^ {32{bad}} : ~pat_q;
    // slow answer, ack one cycle into each request
    assign bus_req = ph_q[1] | hold;
    assign bus_ack = (ph_q == 2'h3) & ~hold;
    assign bus_err = 1'b0;
endmodule
`default_nettype wire

// ---- test/sfr_top_props.sv ----
// checker for the security fault response block
`timescale 1ns/1ps
`default_nettype none
module sfr_props #(
    parameter int MMU_N = 4
) (
    // clock, reset
    input wire logic pclk,
    input wire logic presetn,
    // event sources
    input wire logic cpu_done,
    input wire logic [31:0] cpu_a_res,
    input wire logic [31:0] cpu_b_res,
    input wire logic mem_chk_valid,
    input wire logic mem_err_multi,
    input wire logic mmu_viol,
    input wire logic [3:0] sensor_n,
    input wire logic [1:0] mem_chk_region,
    input wire logic mem_err_single,
    input wire logic nvm_prog_busy,
    input wire logic nvm_tear,
    input wire logic cpu_illegal_op,
    // responses
    input wire logic mem_fix_valid,
    input wire logic nvm_abort,
    input wire logic por_req,
    input wire logic [31:0] mmu_cfg_data,
    input wire logic cpu_halt,
    input wire logic cpu_run,
    input wire logic trap_req,
    input wire logic mmu_cfg_we,
    input wire logic [7:0] mmu_cfg_idx,
    input wire logic chip_rst_req,
    input wire logic secure_state
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_cpu_bad;
        cpu_done && cpu_a_res != cpu_b_res;
    endsequence
    sequence s_rst_burst;
        chip_rst_req [*8];
    endsequence
    property p_cpu_cmp;
        s_cpu_bad |=> secure_state ##0 s_rst_burst;
    endproperty
    property p_mem_fatal;
        mem_chk_valid && mem_err_multi |=> s_rst_burst;
    endproperty
    property p_sensor;
        !(&sensor_n) |-> ##[1:4] cpu_halt;
    endproperty
    property p_halt;
        cpu_halt |-> !cpu_run ##1 cpu_halt;
    endproperty
    property p_mmu;
        mmu_viol |=> trap_req && chip_rst_req;
    endproperty
    property p_init;
        $fell(mmu_cfg_we) |-> cpu_run && $past(mmu_cfg_idx) == 8'(MMU_N - 1);
    endproperty
    property p_init_we;
        mmu_cfg_we |-> !cpu_run;
    endproperty
    property p_sec;
        secure_state |-> !cpu_run;
    endproperty
    sequence s_fix_hit;
        mem_chk_valid && mem_err_single && !mem_err_multi &&
            mem_chk_region == 2'h2;
    endsequence
    property p_fix;
        s_fix_hit |=> mem_fix_valid;
    endproperty
    property p_tear;
        nvm_prog_busy && nvm_tear |=> nvm_abort && por_req;
    endproperty
    property p_opcode;
        cpu_illegal_op |=> secure_state ##0 s_rst_burst;
    endproperty
    property p_cfg_data;
        mmu_cfg_we |-> mmu_cfg_data == {mmu_cfg_idx, 8'h00, 16'h0f00};
    endproperty
    a_cpu_cmp: assert property (p_cpu_cmp) else $error("cpu cmp");
    a_mem_fatal: assert property (p_mem_fatal) else $error("mem fatal");
    a_sensor: assert property (p_sensor) else $error("sensor");
    a_halt: assert property (p_halt) else $error("halt");
    a_mmu: assert property (p_mmu) else $error("mmu");
    a_init: assert property (p_init) else $error("init end");
    a_init_we: assert property (p_init_we) else $error("init run");
    a_sec: assert property (p_sec) else $error("secure run");
    a_fix: assert property (p_fix) else $error("nvm fix");
    a_tear: assert property (p_tear) else $error("tear");
    a_opcode: assert property (p_opcode) else $error("opcode");
    a_cfg_data: assert property (p_cfg_data) else $error("init data");
endmodule
bind sfr_top sfr_props #(.MMU_N(MMU_N)) sfr_props_inst (
    .pclk, .presetn, .cpu_done, .cpu_a_res, .cpu_b_res, .mem_chk_valid,
    .mem_err_multi, .mmu_viol, .sensor_n, .cpu_halt, .cpu_run, .trap_req,
    .mmu_cfg_we, .mmu_cfg_idx, .chip_rst_req, .secure_state,
    .mem_chk_region, .mem_err_single, .nvm_prog_busy, .nvm_tear,
    .cpu_illegal_op, .mem_fix_valid, .nvm_abort, .por_req, .mmu_cfg_data
);
`default_nettype wire

// ---- test/test_security_fault_response.sv ----
// self-checking bench for the security fault response block
`timescale 1ns/1ps
`default_nettype none
module test_security_fault_response;
    import sfr_pkg::*;
    logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, dat, msk, fix, cpu_a_res, cpu_b_res;
    logic err, bad, hold, boot_done, cpu_done, cpu_run, irq;
    logic bus_req, bus_ack, bus_err, chip_rst_req, secure_state;
    logic [6:0] pv;
    logic [3:0] mk, sensor_n;
    int errors, total_checks, cyc;
    sfr_top sfr_top_inst (
        .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mem_chk_valid(pv[0]),
        .mem_chk_region(mk[3:2]), .mem_err_single(mk[1]),
        .mem_err_multi(mk[0]), .mem_raw_data(dat), .mem_flip_mask(msk),
        .mem_fix_data(fix), .mem_fix_valid(), .rom_word_valid(pv[1]),
        .rom_word_last(~mk[2]), .rom_word(dat), .nvm_prog_busy(~mk[2]),
        .nvm_tear(pv[2]), .nvm_abort(), .por_req(), .cpu_done, .cpu_a_res,
        .cpu_b_res, .cpu_illegal_op(pv[5]), .cpu_halt(), .cpu_run,
        .scp_chk_valid(pv[3]), .scp_in(dat), .scp_back(msk), .bus_req,
        .bus_ack, .bus_err, .mmu_viol(pv[4]), .mmu_cfg_we(), .mmu_cfg_idx(),
        .mmu_cfg_data(), .trap_req(), .sensor_n, .boot_done, .chip_rst_req,
        .secure_state, .irq
    );
    sfr_far_side sfr_far_side_inst (
        .pclk, .presetn, .job(pv[6]), .bad, .hold, .cpu_done, .cpu_a_res,
        .cpu_b_res, .bus_req, .bus_ack, .bus_err
    );
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [6:0] v);
        @(posedge pclk);
        pv <= v;
        @(posedge pclk);
        pv <= 7'h00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic fire(input int b);
        mk <= (b == 1) ? 4'ha : 4'h1;
        case (b)
            0, 1: pulse(7'h01);
            2: pulse(7'h02);
            3: pulse(7'h04);
            4: pulse(7'h40);
            5: begin
                sensor_n <= 4'hb;
                tick(3);
                sensor_n <= 4'hf;
            end
            6: begin
                xfer(1'b1, SFR_WDT_PER, 32'h10);
                xfer(1'b1, SFR_CTRL, 32'h4);
                xfer(1'b1, SFR_WDT_KICK, 32'h0);
                tick(24);
                xfer(1'b1, SFR_CTRL, 32'h0);
            end
            7: begin
                xfer(1'b1, SFR_CHKPT, 32'h1);
                xfer(1'b1, SFR_CHKPT, 32'h3);
            end
            8: pulse(7'h08);
            9: begin
                xfer(1'b1, SFR_CTRL, 32'h2);
                hold <= 1'b1;
                tick(72);
                hold <= 1'b0;
                xfer(1'b1, SFR_CTRL, 32'h0);
            end
            10: pulse(7'h10);
            default: begin
                tick(20);
                pulse(7'h20);
            end
        endcase
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    initial begin
        {psel, penable, pwrite, presetn, por_n, bad, hold, boot_done} = '0;
        {paddr, pwdata, pv, mk} = '0;
        dat = 32'h1234_5678;
        msk = 32'h0000_0010;
        sensor_n = 4'hf;
        errors = 0;
        total_checks = 0;
        cyc = 0;
        tick(20);
        presetn <= 1'b1;
        por_n <= 1'b1;
        tick(6);
        chk({31'h0, cpu_run}, 32'h1);
        xfer(1'b0, SFR_CRIT, 32'h0);
        chk(rd, {20'h0, CRIT_RST});
        xfer(1'b0, SFR_WDT_PER, 32'h0);
        chk(rd, WDT_PER_RST);
        xfer(1'b1, 8'h28, 32'hffff_ffff);
        chk({31'h0, err}, 32'h1);
        xfer(1'b0, 8'h28, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(1'b1, SFR_CTRL, 32'h1);
        tick(16);
        xfer(1'b0, SFR_TEST, 32'h0);
        chk(rd, 32'h0);
        boot_done <= 1'b1;
        xfer(1'b1, SFR_CTRL, 32'h1);
        tick(16);
        xfer(1'b0, SFR_TEST, 32'h0);
        chk(rd, 32'h8000_0fff);
        pulse(7'h40);
        mk <= 4'h4;
        pulse(7'h06);
        mk <= 4'h0;
        dat <= 32'h2468_acf0;
        pulse(7'h02);
        dat <= 32'h1234_5678;
        tick(5);
        xfer(1'b0, SFR_STAT, 32'h0);
        chk(rd, 32'h0);
        bad <= 1'b1;
        xfer(1'b1, SFR_MASK, 32'h2);
        xfer(1'b1, SFR_CRIT, 32'h9c0);
        for (int b = 0; b < NSRC; b++) begin
            fire(b);
            tick(4);
            if (b == 11) chk({31'h0, chip_rst_req}, 32'h1);
            xfer(1'b0, SFR_STAT, 32'h0);
            chk(rd, 32'h1 << b);
            chk({31'h0, irq}, {31'h0, b == 1});
            if (b == 1) chk(fix, 32'h1234_5668);
            xfer(1'b1, SFR_STAT, 32'hfff);
        end
        xfer(1'b1, SFR_CTRL, 32'h1);
        xfer(1'b0, SFR_TEST, 32'h0);
        chk({30'h0, rd[31], rd[27]}, 32'h1);
        tick(16);
        xfer(1'b0, SFR_TEST, 32'h0);
        chk(rd, 32'h8000_0fff);
        xfer(1'b0, SFR_STAT, 32'h0);
        chk(rd, 32'h0);
        presetn <= 1'b0;
        tick(3);
        presetn <= 1'b1;
        tick(6);
        xfer(1'b0, SFR_CAUSE, 32'h0);
        chk(rd, 32'hfff);
        xfer(1'b1, SFR_CAUSE, 32'hfff);
        xfer(1'b0, SFR_CAUSE, 32'h0);
        chk(rd, 32'h0);
        results();
    end
endmodule
`default_nettype wire
